// ---- pllcfg_top.sv ----
// Purpose: Register bank that drives the static controls of one analog loop
// Assumes: core_clk 100 MHz, synchronous active-high sys_rst, lock pin asynchronous
// Notes:   Read data stands one cycle after the read strobe
//
// Summary of operation
// - Masked writes change only bits with mask set
// - Bypass bit routes reference clock to output
// - First output divider 14:12, reset three
// - Feedback divider used as stored, no plus
// - Select set: only request B powers down
// - Select clear: divider change or request A
// - Two power-down request bits, reset zero
// - Modulator disable bit 12, reset one
// - Second output divider 8:6, reset one
// - Reference divider 5:0, reset one
// - Bit 27 stops phase and multiplied outputs
// - Bit 26 stops buffered oscillator output
// - Bit 25 stops all other outputs
// - Bit 24 stops noise cancellation converter
// - 24-bit fraction, reset one, over 2^24
// - Write-only spread amplitude, tenths of percent
// - Write-only modulation frequency divider, reset zero
// - Spread shape: zero down, one center
// - Modulator held in reset, reset one
// - Module-level modulator bypass, reset one
// - Integration-level modulator bypass, reset one
//
// Chosen here: the strobed register port.
`timescale 1ns/1ps

module pllcfg_top
  import pllcfg_pkg::*;
#(
  parameter logic [11:0] FBDIV_RST = 12'h064
) (
  // Clock and reset
  input  wire logic        core_clk,
  input  wire logic        sys_rst,
  // Register port
  input  wire logic [15:0] reg_addr,
  input  wire logic [31:0] reg_wdata,
  input  wire logic        reg_wr,
  input  wire logic        reg_rd,
  output logic      [31:0] reg_rdata,
  // Loop status
  input  wire logic        loop_lock_raw,
  // Loop divider controls
  output logic             loop_bypass,
  output logic      [2:0]  first_output_divider,
  output logic      [11:0] feedback_divider,
  output logic      [2:0]  second_output_divider,
  output logic      [5:0]  reference_divider,
  output logic      [23:0] fraction_divider,
  // Loop power controls
  output logic             loop_powerdown,
  output logic             dsm_disable,
  output logic             phase_outputs_off,
  output logic             vco_out_off,
  output logic             post_outputs_off,
  output logic             dac_off,
  // Spread modulator controls
  output logic      [4:0]  spread_amplitude,
  output logic      [3:0]  spread_freq_divider,
  output logic             spread_center,
  output logic             spread_reset,
  output logic             spread_module_bypass,
  output logic             spread_integration_bypass
);

  localparam logic [3:0] PD_CNT_LOAD = 4'(CHANGE_PD_CYCLES);

  logic        bypass_q;
  logic [2:0]  first_output_divider_q;
  logic [11:0] fbdiv_q;
  logic        pdsel_q;
  logic        powerdown_request_b_q;
  logic        powerdown_request_a_q;
  logic        dsmpd_q;
  logic [2:0]  second_output_divider_q;
  logic [5:0]  refdiv_q;
  logic        phasepd_q;
  logic        vcopd_q;
  logic        postpd_q;
  logic        dacpd_q;
  logic [23:0] frac_q;
  logic [4:0]  spread_q;
  logic [3:0]  divval_q;
  logic        center_q;
  logic        ssrst_q;
  logic        ssdis_q;
  logic        ssbp_q;
  logic        lock_meta_q;
  logic        lock_q;
  logic [3:0]  pd_cnt_q;
  logic        pd_q;
  logic [31:0] rdata_q;
  logic        wr_div;
  logic        wr_pwr;
  logic        wr_frac;
  logic        wr_spr;
  logic [15:0] mask;
  logic [15:0] data;
  logic        div_change;
  logic        pd_d;

  // Upper half enables the matching lower bit
  function automatic logic [15:0] apply_mask(input logic [15:0] old_v, input logic [15:0] new_v,
                                             input logic [15:0] msk);
    apply_mask = (old_v & ~msk) | (new_v & msk);
  endfunction

  assign wr_div  = reg_wr && (reg_addr == PLLCFG_DIVIDER_CTRL_OFS);
  assign wr_pwr  = reg_wr && (reg_addr == PLLCFG_POWER_SEL_OFS);
  assign wr_frac = reg_wr && (reg_addr == PLLCFG_FRAC_POWER_OFS);
  assign wr_spr  = reg_wr && (reg_addr == PLLCFG_SPREAD_CTRL_OFS);
  assign mask    = reg_wdata[31:PLLCFG_MASK_LSB];
  assign data    = reg_wdata[15:0];

  // Divider register
  always_ff @(posedge core_clk) begin
    logic [15:0] nv;
    nv = apply_mask({bypass_q, first_output_divider_q, fbdiv_q}, data, mask);
    if (sys_rst) begin
      bypass_q   <= 1'b0;
      first_output_divider_q <= PLLCFG_FIRST_OUTPUT_DIVIDER_RST;
      fbdiv_q    <= FBDIV_RST;
    end else if (wr_div) begin
      bypass_q   <= nv[PLLCFG_BYPASS_BIT];
      first_output_divider_q <= nv[PLLCFG_FIRST_OUTPUT_DIVIDER_LSB +: 3];
      fbdiv_q    <= nv[PLLCFG_FBDIV_LSB +: 12];
    end
  end

  // Power select register; bits 11..9 are not stored
  always_ff @(posedge core_clk) begin
    logic [15:0] nv;
    nv = apply_mask({pdsel_q, powerdown_request_b_q, powerdown_request_a_q, dsmpd_q, 3'h0,
                     second_output_divider_q, refdiv_q}, data, mask);
    if (sys_rst) begin
      pdsel_q               <= 1'b0;
      powerdown_request_b_q <= 1'b0;
      powerdown_request_a_q <= 1'b0;
      dsmpd_q               <= PLLCFG_DSMPD_RST;
      second_output_divider_q            <= PLLCFG_SECOND_OUTPUT_DIVIDER_RST;
      refdiv_q              <= PLLCFG_REFDIV_RST;
    end else if (wr_pwr) begin
      pdsel_q               <= nv[PLLCFG_PDSEL_BIT];
      powerdown_request_b_q <= nv[PLLCFG_PDREQ_B_BIT];
      powerdown_request_a_q <= nv[PLLCFG_PDREQ_A_BIT];
      dsmpd_q               <= nv[PLLCFG_DSMPD_BIT];
      second_output_divider_q            <= nv[PLLCFG_SECOND_OUTPUT_DIVIDER_LSB +: 3];
      refdiv_q              <= nv[PLLCFG_REFDIV_LSB +: 6];
    end
  end

  // Fraction and output power register carries no write mask
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      phasepd_q <= 1'b0;
      vcopd_q   <= 1'b0;
      postpd_q  <= 1'b0;
      dacpd_q   <= 1'b0;
      frac_q    <= PLLCFG_FRAC_RST;
    end else if (wr_frac) begin
      phasepd_q <= reg_wdata[PLLCFG_PHASEPD_BIT];
      vcopd_q   <= reg_wdata[PLLCFG_VCOPD_BIT];
      postpd_q  <= reg_wdata[PLLCFG_POSTPD_BIT];
      dacpd_q   <= reg_wdata[PLLCFG_DACPD_BIT];
      frac_q    <= reg_wdata[PLLCFG_FRAC_LSB +: 24];
    end
  end

  // Spread register, write-only
  always_ff @(posedge core_clk) begin
    logic [15:0] nv;
    nv = apply_mask({3'h0, spread_q, divval_q, center_q, ssrst_q, ssdis_q, ssbp_q},
                    data, mask);
    if (sys_rst) begin
      spread_q <= PLLCFG_SPREAD_RST;
      divval_q <= PLLCFG_DIVVAL_RST;
      center_q <= 1'b0;
      ssrst_q  <= PLLCFG_SSRST_RST;
      ssdis_q  <= PLLCFG_SSDIS_RST;
      ssbp_q   <= PLLCFG_SSBP_RST;
    end else if (wr_spr) begin
      spread_q <= nv[PLLCFG_SPREAD_LSB +: 5];
      divval_q <= nv[PLLCFG_DIVVAL_LSB +: 4];
      center_q <= nv[PLLCFG_CENTER_BIT];
      ssrst_q  <= nv[PLLCFG_SSRST_BIT];
      ssdis_q  <= nv[PLLCFG_SSDIS_BIT];
      ssbp_q   <= nv[PLLCFG_SSBP_BIT];
    end
  end

  // Lock pin synchroniser
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      lock_meta_q <= 1'b0;
      lock_q      <= 1'b0;
    end else begin
      lock_meta_q <= loop_lock_raw;
      lock_q      <= lock_meta_q;
    end
  end

  // A write that alters reference, feedback or fraction divider
  always_comb begin
    logic [15:0] nd;
    logic [15:0] np;
    nd = apply_mask({bypass_q, first_output_divider_q, fbdiv_q}, data, mask);
    np = apply_mask({10'h000, refdiv_q}, data, mask);
    div_change = (wr_div && (nd[11:0] != fbdiv_q))
              || (wr_pwr && (np[5:0] != refdiv_q))
              || (wr_frac && (reg_wdata[23:0] != frac_q));
  end

  // Power-down pulse stretcher for divider changes
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      pd_cnt_q <= 4'h0;
    end else if (div_change) begin
      pd_cnt_q <= PD_CNT_LOAD;
    end else if (pd_cnt_q != 4'h0) begin
      pd_cnt_q <= pd_cnt_q - 4'h1;
    end
  end

  // Power-down source selection
  always_comb begin
    if (pdsel_q) begin
      pd_d = powerdown_request_b_q;
    end else begin
      pd_d = powerdown_request_a_q || (pd_cnt_q != 4'h0) || div_change;
    end
  end

  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      pd_q <= 1'b0;
    end else begin
      pd_q <= pd_d;
    end
  end

  // Read data; write-only, mask and reserved bits read zero
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      rdata_q <= 32'h0000_0000;
    end else if (reg_rd) begin
      case (reg_addr)
        PLLCFG_DIVIDER_CTRL_OFS: rdata_q <= {16'h0000, bypass_q, first_output_divider_q, fbdiv_q};
        PLLCFG_POWER_SEL_OFS:    rdata_q <= {16'h0000, pdsel_q, powerdown_request_b_q,
                                             powerdown_request_a_q, dsmpd_q, 1'b0, lock_q,
                                             1'b0, second_output_divider_q, refdiv_q};
        PLLCFG_FRAC_POWER_OFS:   rdata_q <= {4'h0, phasepd_q, vcopd_q, postpd_q, dacpd_q,
                                             frac_q};
        default:                 rdata_q <= 32'h0000_0000;
      endcase
    end else begin
      rdata_q <= 32'h0000_0000;
    end
  end

  assign reg_rdata                 = rdata_q;
  assign loop_bypass               = bypass_q;
  assign first_output_divider      = first_output_divider_q;
  assign feedback_divider          = fbdiv_q;
  assign second_output_divider     = second_output_divider_q;
  assign reference_divider         = refdiv_q;
  assign fraction_divider          = frac_q;
  assign loop_powerdown            = pd_q;
  assign dsm_disable               = dsmpd_q;
  assign phase_outputs_off         = phasepd_q;
  assign vco_out_off               = vcopd_q;
  assign post_outputs_off          = postpd_q;
  assign dac_off                   = dacpd_q;
  assign spread_amplitude          = spread_q;
  assign spread_freq_divider       = divval_q;
  assign spread_center             = center_q;
  assign spread_reset              = ssrst_q;
  assign spread_module_bypass      = ssdis_q;
  assign spread_integration_bypass = ssbp_q;

  default clocking cb @(posedge core_clk); endclocking
  default disable iff (sys_rst);

  property p_mask_holds;
    reg_wr && reg_addr == PLLCFG_DIVIDER_CTRL_OFS && reg_wdata[31:16] == 16'h0000
      |=> $stable(fbdiv_q) && $stable(first_output_divider_q) && $stable(bypass_q);
  endproperty
  a_mask_holds: assert property (p_mask_holds) else $error("unmasked write changed bits");

  property p_mask_writes;
    reg_wr && reg_addr == PLLCFG_DIVIDER_CTRL_OFS && reg_wdata[31] |=> loop_bypass == $past(reg_wdata[15]);
  endproperty
  a_mask_writes: assert property (p_mask_writes) else $error("bypass not written");

  property p_sel_b_only;
    pdsel_q && !powerdown_request_b_q && $past(pdsel_q) && !$past(powerdown_request_b_q)
      |-> !loop_powerdown;
  endproperty
  a_sel_b_only: assert property (p_sel_b_only) else $error("power-down without request B");

  property p_change_pd;
    !pdsel_q && div_change |=> loop_powerdown [*4];
  endproperty
  a_change_pd: assert property (p_change_pd) else $error("divider change missed power-down");

  property p_req_a;
    !pdsel_q && powerdown_request_a_q |=> loop_powerdown;
  endproperty
  a_req_a: assert property (p_req_a) else $error("request A ignored");

  property p_lock_read;
    reg_rd && reg_addr == PLLCFG_POWER_SEL_OFS |=> reg_rdata[10] == $past(lock_q);
  endproperty
  a_lock_read: assert property (p_lock_read) else $error("lock bit misread");

  property p_lock_sync;
    $rose(loop_lock_raw) ##1 loop_lock_raw |=> lock_q;
  endproperty
  a_lock_sync: assert property (p_lock_sync) else $error("lock not synchronised in two");

  property p_spread_wo;
    reg_rd && reg_addr == PLLCFG_SPREAD_CTRL_OFS |=> reg_rdata == 32'h0000_0000;
  endproperty
  a_spread_wo: assert property (p_spread_wo) else $error("spread register readable");

  property p_frac_write;
    reg_wr && reg_addr == PLLCFG_FRAC_POWER_OFS
      |=> fraction_divider == $past(reg_wdata[23:0]) && dac_off == $past(reg_wdata[24]);
  endproperty
  a_frac_write: assert property (p_frac_write) else $error("fraction write lost");

  property p_rd_one_cycle;
    !reg_rd |=> reg_rdata == 32'h0000_0000;
  endproperty
  a_rd_one_cycle: assert property (p_rd_one_cycle) else $error("read data held too long");

  property p_rst_loop;
    $fell(sys_rst) |-> !loop_bypass && first_output_divider == PLLCFG_FIRST_OUTPUT_DIVIDER_RST
      && feedback_divider == FBDIV_RST && second_output_divider == PLLCFG_SECOND_OUTPUT_DIVIDER_RST
      && reference_divider == PLLCFG_REFDIV_RST && fraction_divider == PLLCFG_FRAC_RST
      && dsm_disable == PLLCFG_DSMPD_RST && !loop_powerdown
      && !phase_outputs_off && !vco_out_off && !post_outputs_off && !dac_off
      && !powerdown_request_a_q && !powerdown_request_b_q;
  endproperty
  a_rst_loop: assert property (p_rst_loop) else $error("loop reset value wrong");

  property p_rst_spread;
    $fell(sys_rst) |-> spread_amplitude == PLLCFG_SPREAD_RST
      && spread_freq_divider == PLLCFG_DIVVAL_RST && !spread_center
      && spread_reset == PLLCFG_SSRST_RST && spread_module_bypass == PLLCFG_SSDIS_RST
      && spread_integration_bypass == PLLCFG_SSBP_RST;
  endproperty
  a_rst_spread: assert property (p_rst_spread) else $error("spread reset value wrong");

  property p_fb_write;
    reg_wr && reg_addr == PLLCFG_DIVIDER_CTRL_OFS && reg_wdata[27:16] == 12'hfff
      |=> feedback_divider == $past(reg_wdata[11:0]);
  endproperty
  a_fb_write: assert property (p_fb_write) else $error("feedback divider not as stored");

  property p_dsm_write;
    reg_wr && reg_addr == PLLCFG_POWER_SEL_OFS && reg_wdata[28]
      |=> dsm_disable == $past(reg_wdata[12]);
  endproperty
  a_dsm_write: assert property (p_dsm_write) else $error("modulator disable not written");

  property p_ref_write;
    reg_wr && reg_addr == PLLCFG_POWER_SEL_OFS && reg_wdata[24:16] == 9'h1ff
      |=> second_output_divider == $past(reg_wdata[8:6])
          && reference_divider == $past(reg_wdata[5:0]);
  endproperty
  a_ref_write: assert property (p_ref_write) else $error("divider fields not written");

  property p_outs_write;
    reg_wr && reg_addr == PLLCFG_FRAC_POWER_OFS
      |=> {phase_outputs_off, vco_out_off, post_outputs_off} == $past(reg_wdata[27:25]);
  endproperty
  a_outs_write: assert property (p_outs_write) else $error("output power-downs lost");

  property p_amp_write;
    reg_wr && reg_addr == PLLCFG_SPREAD_CTRL_OFS && reg_wdata[28:24] == 5'h1f
      |=> spread_amplitude == $past(reg_wdata[12:8]);
  endproperty
  a_amp_write: assert property (p_amp_write) else $error("spread amplitude not written");

  c_bypass:    cover property (wr_div ##1 loop_bypass);
  c_change_pd: cover property (div_change ##1 loop_powerdown);
  c_sel_b:     cover property (pdsel_q && powerdown_request_b_q ##1 loop_powerdown);
  c_spread:    cover property (wr_spr ##1 !spread_reset && !spread_module_bypass);
  c_lock:      cover property ($rose(lock_q));

endmodule

// ---- pllcfg_pkg.sv ----
// Purpose: Constants shared by the loop configuration block
// Assumes: 32-bit register port, byte addresses
// Notes:   Upper half of a masked register write is a per-bit write enable
package pllcfg_pkg;

  // Register byte offsets
  localparam logic [15:0] PLLCFG_DIVIDER_CTRL_OFS  = 16'h0000;
  localparam logic [15:0] PLLCFG_POWER_SEL_OFS     = 16'h0004;
  localparam logic [15:0] PLLCFG_FRAC_POWER_OFS    = 16'h0008;
  localparam logic [15:0] PLLCFG_SPREAD_CTRL_OFS   = 16'h000c;

  // Write mask field
  localparam int PLLCFG_MASK_LSB = 16;

  // Divider register fields
  localparam int PLLCFG_BYPASS_BIT  = 15;
  localparam int PLLCFG_FIRST_OUTPUT_DIVIDER_LSB = 12;
  localparam int PLLCFG_FBDIV_LSB    = 0;

  // Power select register fields
  localparam int PLLCFG_PDSEL_BIT    = 15;
  localparam int PLLCFG_PDREQ_B_BIT  = 14;
  localparam int PLLCFG_PDREQ_A_BIT  = 13;
  localparam int PLLCFG_DSMPD_BIT    = 12;
  localparam int PLLCFG_LOCK_BIT     = 10;
  localparam int PLLCFG_SECOND_OUTPUT_DIVIDER_LSB = 6;
  localparam int PLLCFG_REFDIV_LSB   = 0;

  // Fraction and output power register fields
  localparam int PLLCFG_PHASEPD_BIT  = 27;
  localparam int PLLCFG_VCOPD_BIT    = 26;
  localparam int PLLCFG_POSTPD_BIT   = 25;
  localparam int PLLCFG_DACPD_BIT    = 24;
  localparam int PLLCFG_FRAC_LSB     = 0;

  // Spread register fields
  localparam int PLLCFG_SPREAD_LSB   = 8;
  localparam int PLLCFG_DIVVAL_LSB   = 4;
  localparam int PLLCFG_CENTER_BIT   = 3;
  localparam int PLLCFG_SSRST_BIT    = 2;
  localparam int PLLCFG_SSDIS_BIT    = 1;
  localparam int PLLCFG_SSBP_BIT     = 0;

  // Reset values
  localparam logic [2:0]  PLLCFG_FIRST_OUTPUT_DIVIDER_RST = 3'h3;
  localparam logic [2:0]  PLLCFG_SECOND_OUTPUT_DIVIDER_RST = 3'h1;
  localparam logic [5:0]  PLLCFG_REFDIV_RST   = 6'h01;
  localparam logic        PLLCFG_DSMPD_RST    = 1'h1;
  localparam logic [23:0] PLLCFG_FRAC_RST     = 24'h000001;
  localparam logic [4:0]  PLLCFG_SPREAD_RST   = 5'h00;
  localparam logic [3:0]  PLLCFG_DIVVAL_RST   = 4'h0;
  localparam logic        PLLCFG_SSRST_RST    = 1'h1;
  localparam logic        PLLCFG_SSDIS_RST    = 1'h1;
  localparam logic        PLLCFG_SSBP_RST     = 1'h1;

  // Power-down pulse after a divider change
  localparam int CLK_PERIOD_NS      = 10;
  localparam int CHANGE_PD_NS       = 40;
  localparam int CHANGE_PD_CYCLES   = (CHANGE_PD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

endpackage

// ---- pllcfg_loop_model.sv ----
// Purpose: Behavioural analog loop that reports lock to the configuration block
// Assumes: Lock drops while powered down and returns after a settle time
// Notes:   Runs from core_clk and ignores sys_rst, as an analog macro would
`timescale 1ns/1ps

module pllcfg_loop_model #(
  parameter int LOCK_CYCLES = 16
) (
  // Clock
  input  wire logic core_clk,
  // Loop control
  input  wire logic loop_powerdown,
  // Loop status
  output logic      loop_lock_raw
);
  int cnt_q = 0;

  // Settle counter restarts on every power-down
  always @(posedge core_clk) begin
    if (loop_powerdown)
      cnt_q <= 0;
    else if (cnt_q < LOCK_CYCLES)
      cnt_q <= cnt_q + 1;
  end

  assign loop_lock_raw = (cnt_q == LOCK_CYCLES);
endmodule

// ---- tb_pllcfg_top.sv ----
// Purpose: Self-checking bench for the loop configuration register bank
// Assumes: Loop model supplies lock; bench models the register contents
// Notes:   Random masked writes mixed with power-down and lock corner cases
`timescale 1ns/1ps

module tb_pllcfg_top;
  import pllcfg_pkg::*;

  localparam logic [11:0] FB_RST = 12'h064;
  localparam logic [31:0] RWM [4] = '{32'h0000ffff, 32'h0000f1ff, 32'h0fffffff, 32'h00001fff};
  localparam logic [15:0] FM [4][7] = '{
    '{16'h8000, 16'h7000, 16'h0fff, 16'h0, 16'h0, 16'h0, 16'h0},
    '{16'h8000, 16'h4000, 16'h2000, 16'h1000, 16'h0e00, 16'h01c0, 16'h003f},
    '{7{16'h0}},
    '{16'h1f00, 16'h00f0, 16'h0008, 16'h0004, 16'h0002, 16'h0001, 16'he000}};

  logic        core_clk = 1'b0, sys_rst = 1'b1, reg_wr = 1'b0, reg_rd = 1'b0;
  logic [15:0] reg_addr = 16'h0;
  logic [31:0] reg_wdata = 32'h0, reg_rdata, d;
  logic        loop_lock_raw, loop_bypass, loop_powerdown, dsm_disable;
  logic [2:0]  first_output_divider, second_output_divider;
  logic [11:0] feedback_divider;
  logic [5:0]  reference_divider;
  logic [23:0] fraction_divider;
  logic        phase_outputs_off, vco_out_off, post_outputs_off, dac_off;
  logic [4:0]  spread_amplitude;
  logic [3:0]  spread_freq_divider;
  logic        spread_center, spread_reset, spread_module_bypass, spread_integration_bypass;
  logic [31:0] e [4];
  int          num_errors = 0, total_checks = 0, r;

  pllcfg_top #(.FBDIV_RST(FB_RST)) i_pllcfg_top (
    .core_clk, .sys_rst, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
    .loop_lock_raw, .loop_bypass, .first_output_divider, .feedback_divider,
    .second_output_divider, .reference_divider, .fraction_divider, .loop_powerdown,
    .dsm_disable, .phase_outputs_off, .vco_out_off, .post_outputs_off, .dac_off,
    .spread_amplitude, .spread_freq_divider, .spread_center, .spread_reset,
    .spread_module_bypass, .spread_integration_bypass);

  pllcfg_loop_model i_pllcfg_loop_model (.core_clk, .loop_powerdown, .loop_lock_raw);

  initial begin
    forever #5 core_clk = ~core_clk;
  end

  task automatic final_report;
    if (num_errors == 0 && total_checks > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask

  task automatic chk(input string nm, input logic [31:0] x, input logic [31:0] g);
    total_checks++;
    if (g !== x) begin
      num_errors++;
      $display("BAD %s expected %h seen %h", nm, x, g);
    end
  endtask

  // Lower bits change only where the upper half enables them; 0x8 has no mask
  function automatic logic [31:0] upd(int k, logic [31:0] o, logic [31:0] w);
    logic [31:0] m;
    m = (k == 2) ? RWM[k] : ({16'h0, w[31:16]} & RWM[k]);
    return (o & ~m) | (w & m);
  endfunction

  // Legal random contents, mask set whole field at a time
  function automatic logic [31:0] rv(int k);
    logic [15:0] m;
    logic [31:0] v;
    m = 16'h0;
    for (int f = 0; f < 7; f++)
      if ($urandom % 2) m |= FM[k][f];
    case (k)
      0: v = {16'h0, 1'($urandom), 3'(1 + $urandom % 7), 12'(20 + $urandom % 301)};
      1: v = {16'h0, 4'($urandom), 3'h7, 3'(1 + $urandom % 7), 6'(1 + $urandom % 63)};
      2: v = $urandom;
      default: v = {16'h0, 16'($urandom)};
    endcase
    return (k == 2) ? v : {m, v[15:0]};
  endfunction

  task automatic wr(input logic [15:0] a, input logic [31:0] w);
    @(posedge core_clk);
    reg_wr    <= 1'b1;
    reg_addr  <= a;
    reg_wdata <= w;
    @(posedge core_clk);
    reg_wr <= 1'b0;
    if (a < 16'h10 && a[1:0] == 2'b0)
      e[a[3:2]] = upd(a[3:2], e[a[3:2]], w);
  endtask

  task automatic rd(input logic [15:0] a, output logic [31:0] q);
    @(posedge core_clk);
    reg_rd   <= 1'b1;
    reg_addr <= a;
    @(posedge core_clk);
    reg_rd <= 1'b0;
    #1 q = reg_rdata;
  endtask

  // Readback of all places plus one unmapped address; lock bit checked apart
  task automatic chk_regs;
    logic [31:0] q;
    for (int i = 0; i < 5; i++) begin
      rd(16'(i * 4), q);
      if (i == 1)
        q[10] = 1'b0;
      chk("rdata", (i < 3) ? (e[i] & RWM[i]) : 32'h0, q);
    end
  endtask

  task automatic chk_outs;
    @(posedge core_clk);
    #1;
    chk("div", 32'(e[0][15:0]), 32'({loop_bypass, first_output_divider, feedback_divider}));
    chk("sel", 32'({e[1][12], e[1][8:0]}),
        32'({dsm_disable, second_output_divider, reference_divider}));
    chk("frac", 32'(e[2][27:0]), 32'({phase_outputs_off, vco_out_off, post_outputs_off,
        dac_off, fraction_divider}));
    chk("spread", 32'(e[3][12:0]), 32'({spread_amplitude, spread_freq_divider, spread_center,
        spread_reset, spread_module_bypass, spread_integration_bypass}));
  endtask

  // Counts power-down cycles starting just after the current edge
  task automatic pdc(input int n, input int x);
    int c;
    c = 0;
    repeat (n) begin
      #1;
      if (loop_powerdown === 1'b1)
        c++;
      @(posedge core_clk);
    end
    chk("powerdown", x, c);
  endtask

  task automatic rst;
    sys_rst <= 1'b1;
    repeat (16) @(posedge core_clk);
    sys_rst <= 1'b0;
    e = '{{16'h0, 4'h3, FB_RST}, 32'h00001041, 32'h00000001, 32'h00000007};
    chk_outs;
    chk_regs;
    chk("pd_rst", 32'h0, 32'(loop_powerdown));
  endtask

  initial begin
    #100000;
    num_errors++;
    final_report;
  end

  initial begin
    void'($urandom(18683));
    rst;
    for (int t = 0; t < 40; t++) begin
      r = $urandom % 5;
      if (r == 4)
        wr(16'h0010, $urandom);
      else
        wr(16'(r * 4), rv(r));
      chk_outs;
      if (t % 8 == 7)
        chk_regs;
    end
    wr(16'h4, 32'he000_0000);
    repeat (10) @(posedge core_clk);
    wr(16'h8, e[2] ^ 32'h1);
    pdc(12, CHANGE_PD_CYCLES + 1);
    wr(16'h8, e[2]);
    pdc(12, 0);
    wr(16'h0, {16'h0fff, 4'h0, (e[0][11:0] == 12'd100) ? 12'd200 : 12'd100});
    pdc(12, CHANGE_PD_CYCLES + 1);
    wr(16'h4, {16'h003f, 10'h0, (e[1][5:0] == 6'd1) ? 6'd2 : 6'd1});
    pdc(12, CHANGE_PD_CYCLES + 1);
    wr(16'h4, 32'h2000_2000);
    repeat (2) @(posedge core_clk);
    pdc(8, 8);
    wr(16'h4, 32'h2000_0000);
    repeat (3) @(posedge core_clk);
    pdc(8, 0);
    wr(16'h4, 32'h8000_8000);
    repeat (3) @(posedge core_clk);
    wr(16'h8, e[2] ^ 32'h1);
    pdc(12, 0);
    wr(16'h4, 32'h2000_2000);
    pdc(12, 0);
    wr(16'h4, 32'h6000_4000);
    repeat (2) @(posedge core_clk);
    pdc(8, 8);
    rd(16'h4, d);
    chk("lock", 32'h0, 32'(d[10]));
    wr(16'h4, 32'h4000_0000);
    repeat (40) @(posedge core_clk);
    wr(16'h4, 32'h0400_0000);
    rd(16'h4, d);
    chk("lock", 32'h1, 32'(d[10]));
    chk_regs;
    rst;
    final_report;
  end
endmodule
